// ### bench/flash_array_model.sv
`timescale 1ns/1ps
// ****************
// flash array side
// ****************
module flash_array_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pump_en,
	input  wire logic        hv_pulse,
	output logic      [15:0] pre_cnt,
	output logic      [15:0] pulse_cnt,
	output logic      [15:0] post_cnt
);
	logic pump_q;
	logic seen;
	// measures the pump time before, during and after the pulse so the bench can judge the timing
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pump_q <= 1'b0;
			seen <= 1'b0;
			pre_cnt <= 16'h0000;
			pulse_cnt <= 16'h0000;
			post_cnt <= 16'h0000;
		end else begin
			pump_q <= pump_en;
			if (pump_en && !pump_q) begin
				pre_cnt <= 16'h0001;
				pulse_cnt <= 16'h0000;
				post_cnt <= 16'h0000;
				seen <= 1'b0;
			end else if (hv_pulse) begin
				pulse_cnt <= pulse_cnt + 16'h0001;
				seen <= 1'b1;
			end else if (pump_en && seen) begin
				post_cnt <= post_cnt + 16'h0001;
			end else if (pump_en) begin
				pre_cnt <= pre_cnt + 16'h0001;
			end
		end
	end
endmodule

// ### bench/flash_program_erase_timer_tb_top.sv
`timescale 1ns/1ps
// ****************
// bench top
// ****************
module flash_program_erase_timer_tb_top;
	import flash_timer_pkg::*;
	// counts far below the floors
	// software keeps, so runs stay short; the formulas are the same
	// a divisor above one makes a misaligned first start tick show up
	localparam int PD = 2, PS = 1, PP = 2, PE = 1, PT = 2, PN = 1;
	localparam int DD = 0, DS = 3, DP = 4, DE = 0, DT = 1, DN = 2;
	logic mclk = 1'b0, rst = 1'b1;
	logic pm_go = 1'b0, pm_esel = 1'b0;
	logic dm_go = 1'b0, dm_esel = 1'b0, dm_isp = 1'b0;
	logic [DIV_W-1:0] pm_d = DIV_W'(PD), dm_d = DIV_W'(DD);
	logic [CNT_W-1:0] pm_s = CNT_W'(PS), pm_p = CNT_W'(PP);
	logic [CNT_W-1:0] pm_e = CNT_W'(PE), pm_t = CNT_W'(PT);
	logic [CNT_W-1:0] pm_n = CNT_W'(PN), dm_s = CNT_W'(DS);
	logic [CNT_W-1:0] dm_p = CNT_W'(DP), dm_e = CNT_W'(DE);
	logic [CNT_W-1:0] dm_t = CNT_W'(DT), dm_n = CNT_W'(DN);
	logic pm_busy, pm_pump, pm_hv, pm_her, pm_done;
	logic dm_busy, dm_pump, dm_hv, dm_her, dm_done, isp_t;
	logic [15:0] pm_pre, pm_pul, pm_post, dm_pre, dm_pul, dm_post;
	int err_total = 0;
	int comparisons = 0;
	always #2 mclk = ~mclk;
	flash_program_erase_timer u_dut (.MCLK(mclk), .RST(rst),
		.PROGMEM_PRESCALE(pm_d), .PROGMEM_PULSE(pm_p), .PROGMEM_ERASE(pm_e),
		.PROGMEM_START(pm_s), .PROGMEM_TRANSITION(pm_t), .PROGMEM_END(pm_n),
		.PROGMEM_GO(pm_go), .PROGMEM_ERASE_SEL(pm_esel),
		.PROGMEM_BUSY(pm_busy), .PROGMEM_PUMP_EN(pm_pump),
		.PROGMEM_HV_PULSE(pm_hv), .PROGMEM_HV_ERASE(pm_her),
		.PROGMEM_DONE(pm_done), .DATAMEM_PRESCALE(dm_d),
		.DATAMEM_PULSE(dm_p), .DATAMEM_ERASE(dm_e), .DATAMEM_START(dm_s),
		.DATAMEM_TRANSITION(dm_t), .DATAMEM_END(dm_n), .DATAMEM_GO(dm_go),
		.DATAMEM_ERASE_SEL(dm_esel), .DATAMEM_ISP_SEL(dm_isp),
		.DATAMEM_BUSY(dm_busy), .DATAMEM_PUMP_EN(dm_pump),
		.DATAMEM_HV_PULSE(dm_hv), .DATAMEM_HV_ERASE(dm_her),
		.DATAMEM_DONE(dm_done), .ISP_TARGET(isp_t));
	flash_array_model pm_arr (.clk(mclk), .rst(rst), .pump_en(pm_pump),
		.hv_pulse(pm_hv), .pre_cnt(pm_pre), .pulse_cnt(pm_pul),
		.post_cnt(pm_post));
	flash_array_model dm_arr (.clk(mclk), .rst(rst), .pump_en(dm_pump),
		.hv_pulse(dm_hv), .pre_cnt(dm_pre), .pulse_cnt(dm_pul),
		.post_cnt(dm_post));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hold > 1 keeps the request up while busy, where it must be ignored
	task automatic op(input bit dm, input bit er, input bit isp,
		input int hold, input int pre, input int pul);
		int n;
		int post;
		post = dm ? (DD + 1) * (DN + 1) + 1 : (PD + 1) * (PN + 1) + 1;
		n = 0;
		if (dm) begin
			dm_go <= 1'b1;
			dm_esel <= er;
			dm_isp <= isp;
		end else begin
			pm_go <= 1'b1;
			pm_esel <= er;
		end
		repeat (hold) @(posedge mclk);
		dm_go <= 1'b0;
		pm_go <= 1'b0;
		while ((dm ? dm_done : pm_done) !== 1'b1 && n < 5000) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
		@(negedge mclk);
		chk(16'(n >= 5000), 16'h0000, "done timeout");
		chk(dm ? dm_pre : pm_pre, 16'(pre), "start delay");
		chk(dm ? dm_pul : pm_pul, 16'(pul), "pulse width");
		chk(dm ? dm_post : pm_post, 16'(post), "end delay");
		chk(16'(dm ? dm_her : pm_her), 16'(er), "pulse kind");
		chk(16'(dm ? dm_busy : pm_busy), 16'h0000, "busy after");
		if (dm)
			chk(16'(isp_t), 16'(isp), "isp target");
		$display("op done mem=%0d erase=%0d", dm, er);
		@(posedge mclk);
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		give_verdict;
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		op(0, 0, 0, 3, (PD + 1) * (PS + 1), (PD + 1) * (PP + 1));
		op(0, 1, 0, 1, (PD + 1) * (PS + 1) + (PD + 1) * (PT + 1),
			(PD + 1) * 4 * (PE + 1));
		op(0, 1, 0, 1, (PD + 1) * (PS + 1), (PD + 1) * 4 * (PE + 1));
		op(1, 1, 1, 1, (DD + 1) * (DS + 1), (DD + 1) * 4 * (DE + 1));
		op(1, 0, 0, 1, (DD + 1) * (DS + 1) + (DD + 1) * (DT + 1),
			(DD + 1) * (DP + 1));
		repeat (3)
			op(1, 0, 0, 1, (DD + 1) * (DS + 1), (DD + 1) * (DP + 1));
		give_verdict;
	end
endmodule

// ### bench/flash_timer_monitor.sv
`timescale 1ns/1ps
// ****************
// port checks
// ****************
module flash_timer_monitor
	import flash_timer_pkg::*;
(
	input wire logic             MCLK,
	input wire logic             RST,
	input wire logic [DIV_W-1:0] PROGMEM_PRESCALE,
	input wire logic [CNT_W-1:0] PROGMEM_PULSE,
	input wire logic [CNT_W-1:0] PROGMEM_ERASE,
	input wire logic             PROGMEM_BUSY,
	input wire logic             PROGMEM_PUMP_EN,
	input wire logic             PROGMEM_HV_PULSE,
	input wire logic             PROGMEM_HV_ERASE,
	input wire logic             PROGMEM_DONE,
	input wire logic             DATAMEM_GO,
	input wire logic             DATAMEM_BUSY,
	input wire logic             DATAMEM_ISP_SEL,
	input wire logic             ISP_TARGET
);
	logic [31:0] len_reg;
	logic [31:0] prog_len;
	logic [31:0] er_len;
	// settings stay put while busy, so live ports give the target
	assign prog_len = (32'(PROGMEM_PRESCALE) + 32'h1)
		* (32'(PROGMEM_PULSE) + 32'h1);
	assign er_len = (32'(PROGMEM_PRESCALE) + 32'h1) * 32'h4
		* (32'(PROGMEM_ERASE) + 32'h1);
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			len_reg <= 32'h0;
		else
			len_reg <= PROGMEM_HV_PULSE ? len_reg + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	pulse_in_pump_a: assert property (
		PROGMEM_HV_PULSE |-> PROGMEM_PUMP_EN) else $error("pulse off pump");
	addr_hold_a: assert property (
		$rose(PROGMEM_BUSY) |-> !PROGMEM_PUMP_EN [*2] ##[1:3] PROGMEM_PUMP_EN)
		else $error("address hold wrong");
	pump_hold_a: assert property (
		$fell(PROGMEM_HV_PULSE) |-> PROGMEM_PUMP_EN [*2])
		else $error("pump dropped early");
	done_end_a: assert property (
		PROGMEM_DONE |-> PROGMEM_PUMP_EN ##1 !PROGMEM_PUMP_EN)
		else $error("done not at pump end");
	pulse_kind_a: assert property (
		PROGMEM_HV_PULSE && $past(PROGMEM_HV_PULSE)
		|-> $stable(PROGMEM_HV_ERASE)) else $error("kind changed");
	prog_len_a: assert property (
		$fell(PROGMEM_HV_PULSE) && !PROGMEM_HV_ERASE |-> len_reg == prog_len)
		else $error("program pulse length");
	erase_len_a: assert property (
		$fell(PROGMEM_HV_PULSE) && PROGMEM_HV_ERASE |-> len_reg == er_len)
		else $error("erase pulse length");
	isp_sel_a: assert property (
		DATAMEM_GO && !DATAMEM_BUSY |=> ISP_TARGET == $past(DATAMEM_ISP_SEL))
		else $error("isp target not captured");
	cover property ($fell(PROGMEM_HV_PULSE) && PROGMEM_HV_ERASE);
	cover property (PROGMEM_DONE);
	cover property (ISP_TARGET && DATAMEM_BUSY);
endmodule
bind flash_program_erase_timer flash_timer_monitor u_mon (.*);

// ### rtl/flash_program_erase_timer.sv
`timescale 1ns/1ps
// What this block does, and the limits software keeps
// [RL1] program pulse lasts (divisor+1)*(program count+1) clocks
// [RL2] erase pulse lasts (divisor+1)*4*(erase count+1) clocks
// [RL3] pump start delay (divisor+1)*(start count+1) clocks before pulse
// [RL4] transition interval (divisor+1)*(transition count+1) on switch
// [RL5] pump kept on (divisor+1)*(end count+1) clocks after pulse
// [RL6] software keeps program pulse between 30 and 40 us
// [RL7] software keeps erase pulse at least 1 ms
// [RL8] software keeps pump start delay at least 10 us
// [RL9] software keeps transition interval at least 5 us
// [RL10] software keeps pump end delay at least 5 us
// [RL11] program address held and set up at least 2 clocks
// [RL12] pump enable held at least 1 clock beyond the hold point
// [RL13] software keeps row high-voltage exposure under 25 ms since erase
// [RL14] data rewrite is one erase then four byte programs, >=1.32 ms
// [RL15] data memory instance has its own divisor and counts
// [RL16] isp memory timed by the data memory instance
// [RL17] phases run start delay, pulse, end delay; transition on switch
module flash_program_erase_timer
	import flash_timer_pkg::*;
(
	input  wire logic             MCLK,
	input  wire logic             RST,
	// program memory timing settings
	input  wire logic [DIV_W-1:0] PROGMEM_PRESCALE,
	input  wire logic [CNT_W-1:0] PROGMEM_PULSE,
	input  wire logic [CNT_W-1:0] PROGMEM_ERASE,
	input  wire logic [CNT_W-1:0] PROGMEM_START,
	input  wire logic [CNT_W-1:0] PROGMEM_TRANSITION,
	input  wire logic [CNT_W-1:0] PROGMEM_END,
	input  wire logic             PROGMEM_GO,
	input  wire logic             PROGMEM_ERASE_SEL,
	output logic                  PROGMEM_BUSY,
	output logic                  PROGMEM_PUMP_EN,
	output logic                  PROGMEM_HV_PULSE,
	output logic                  PROGMEM_HV_ERASE,
	output logic                  PROGMEM_DONE,
	// data memory timing settings
	input  wire logic [DIV_W-1:0] DATAMEM_PRESCALE,
	input  wire logic [CNT_W-1:0] DATAMEM_PULSE,
	input  wire logic [CNT_W-1:0] DATAMEM_ERASE,
	input  wire logic [CNT_W-1:0] DATAMEM_START,
	input  wire logic [CNT_W-1:0] DATAMEM_TRANSITION,
	input  wire logic [CNT_W-1:0] DATAMEM_END,
	input  wire logic             DATAMEM_GO,
	input  wire logic             DATAMEM_ERASE_SEL,
	input  wire logic             DATAMEM_ISP_SEL,
	output logic                  DATAMEM_BUSY,
	output logic                  DATAMEM_PUMP_EN,
	output logic                  DATAMEM_HV_PULSE,
	output logic                  DATAMEM_HV_ERASE,
	output logic                  DATAMEM_DONE,
	output logic                  ISP_TARGET
);
	// ********************************************
	// settings registers, one set per instance
	// ********************************************
	timing_cfg_t progmem_cfg_reg;
	timing_cfg_t datamem_cfg_reg;
	logic        isp_reg;
	logic        pm_busy_reg;
	logic        dm_busy_reg;

	phase_if pm ();
	phase_if dm ();

	// settings only load while idle so a running pulse keeps its width
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			progmem_cfg_reg <= '{DIV_RST, CNT_RST, CNT_RST, CNT_RST,
				CNT_RST, CNT_RST};
		end else if (!pm.busy) begin
			progmem_cfg_reg <= '{PROGMEM_PRESCALE, PROGMEM_PULSE,
				PROGMEM_ERASE, PROGMEM_START, PROGMEM_TRANSITION,
				PROGMEM_END};
		end
	end

	// [RL15] separate data memory settings
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			datamem_cfg_reg <= '{DIV_RST, CNT_RST, CNT_RST, CNT_RST,
				CNT_RST, CNT_RST};
		end else if (!dm.busy) begin
			datamem_cfg_reg <= '{DATAMEM_PRESCALE, DATAMEM_PULSE,
				DATAMEM_ERASE, DATAMEM_START, DATAMEM_TRANSITION,
				DATAMEM_END};
		end
	end

	// [RL16] isp shares the data memory timer
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			isp_reg <= 1'b0;
		else if (DATAMEM_GO && !dm.busy)
			isp_reg <= DATAMEM_ISP_SEL;
	end

	// settings reach the sequencer one cycle after go, so go is delayed
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pm_busy_reg <= 1'b0;
			dm_busy_reg <= 1'b0;
		end else begin
			pm_busy_reg <= PROGMEM_GO && !pm.busy;
			dm_busy_reg <= DATAMEM_GO && !dm.busy;
		end
	end

	logic pm_sel_reg;
	logic dm_sel_reg;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			pm_sel_reg <= 1'b0;
			dm_sel_reg <= 1'b0;
		end else begin
			pm_sel_reg <= PROGMEM_ERASE_SEL;
			dm_sel_reg <= DATAMEM_ERASE_SEL;
		end
	end

	assign pm.cfg   = progmem_cfg_reg;
	assign pm.start = pm_busy_reg;
	assign pm.erase = pm_sel_reg;
	assign dm.cfg   = datamem_cfg_reg;
	assign dm.start = dm_busy_reg;
	assign dm.erase = dm_sel_reg;

	// ********************************************
	// timing engines
	// ********************************************
	phase_sequencer u_progmem (
		.clk (MCLK),
		.rst (RST),
		.p   (pm.seq)
	);

	// [RL14] each rewrite step is one run
	phase_sequencer u_datamem (
		.clk (MCLK),
		.rst (RST),
		.p   (dm.seq)
	);

	// [RL12] pump enable outlasts the pulse
	assign PROGMEM_BUSY     = pm.busy || pm_busy_reg;
	assign PROGMEM_PUMP_EN  = pm.pump_on;
	assign PROGMEM_HV_PULSE = pm.pulse_on;
	assign PROGMEM_HV_ERASE = pm.is_erase;
	assign PROGMEM_DONE     = pm.done;
	assign DATAMEM_BUSY     = dm.busy || dm_busy_reg;
	assign DATAMEM_PUMP_EN  = dm.pump_on;
	assign DATAMEM_HV_PULSE = dm.pulse_on;
	assign DATAMEM_HV_ERASE = dm.is_erase;
	assign DATAMEM_DONE     = dm.done;
	assign ISP_TARGET       = isp_reg;
endmodule

// ### rtl/flash_timer_pkg.sv
package flash_timer_pkg;
	// register widths, as a microcontroller peripheral would hold them
	localparam int DIV_W   = 8;
	localparam int CNT_W   = 16;
	localparam int TICK_W  = 10;
	// erase phase counts four prescaled ticks per count step
	localparam logic [1:0] ERASE_MULT_M1 = 2'h3;
	// reset values of the count registers
	localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	// least address hold and pump enable hold, in clock cycles
	localparam logic [1:0] ADDR_HOLD_CYC = 2'h2;
	localparam logic [1:0] PUMP_HOLD_CYC = 2'h1;
	// clock rate and the smallest 1.32 ms rewrite period in cycles
	localparam int CLK_MHZ       = 250;
	localparam int REWRITE_US_X100 = 132000;
	localparam int REWRITE_CYC   = REWRITE_US_X100 * CLK_MHZ / 100;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_START  = 7'h02,
		ST_PULSE  = 7'h04,
		ST_TRAN   = 7'h08,
		ST_END    = 7'h10,
		ST_HOLD   = 7'h20,
		ST_PUMPHD = 7'h40
	} phase_t;

	// one timing instance's settings
	typedef struct packed {
		logic [DIV_W-1:0] prescale_divisor;
		logic [CNT_W-1:0] program_pulse_count;
		logic [CNT_W-1:0] erase_pulse_count;
		logic [CNT_W-1:0] pump_start_count;
		logic [CNT_W-1:0] transition_count;
		logic [CNT_W-1:0] pump_end_count;
	} timing_cfg_t;
endpackage

// ### rtl/phase_if.sv
`timescale 1ns/1ps
interface phase_if;
	import flash_timer_pkg::*;
	timing_cfg_t      cfg;
	logic             start;
	logic             erase;
	logic             busy;
	logic             pump_on;
	logic             pulse_on;
	logic             is_erase;
	logic             done;
	modport ctrl (output cfg, start, erase,
		input busy, pump_on, pulse_on, is_erase, done);
	modport seq (input cfg, start, erase,
		output busy, pump_on, pulse_on, is_erase, done);
endinterface

// ### rtl/phase_sequencer.sv
`timescale 1ns/1ps
module phase_sequencer
	import flash_timer_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	phase_if.seq      p
);
	phase_t           state_reg;
	logic [DIV_W-1:0] pre_reg;
	logic [CNT_W+1:0] cnt_reg;
	logic [1:0]       hold_reg;
	logic             erase_reg;
	logic             last_erase_reg;
	logic             ran_reg;
	logic             tick;

	// load value for a phase: count plus one steps, erase times four
	function automatic logic [CNT_W+1:0] steps(input logic [CNT_W-1:0] c,
		input logic x4);
		logic [CNT_W+1:0] s;
		s = {2'h0, c};
		if (x4)
			s = {c, ERASE_MULT_M1};
		return s;
	endfunction

	assign tick = (pre_reg == p.cfg.prescale_divisor);

	// ********************************************
	// prescaler: one tick each divisor+1 clocks
	// ********************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pre_reg <= DIV_RST;
		// restart in the hold phase so the start delay begins on a full tick
		else if (state_reg == ST_IDLE || state_reg == ST_HOLD
			|| tick)
			pre_reg <= '0;
		else
			pre_reg <= pre_reg + 1'b1;
	end

	// ********************************************
	// phase order
	// ********************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg      <= ST_IDLE;
			cnt_reg        <= '0;
			hold_reg       <= '0;
			erase_reg      <= 1'b0;
			last_erase_reg <= 1'b0;
			ran_reg        <= 1'b0;
		end else begin
			unique case (state_reg)
			ST_IDLE: begin
				if (p.start) begin
					erase_reg <= p.erase;
					hold_reg  <= ADDR_HOLD_CYC - 2'h1;
					state_reg <= ST_HOLD;
				end
			end
			// [RL11] address setup hold
			ST_HOLD: begin
				if (hold_reg == 2'h0) begin
					cnt_reg   <= steps(p.cfg.pump_start_count, 1'b0);
					state_reg <= ST_START;
				end else
					hold_reg <= hold_reg - 2'h1;
			end
			// [RL3] pump start delay
			ST_START: begin
				if (tick) begin
					if (cnt_reg == '0) begin
						// [RL4] switch program/erase
						if (ran_reg && last_erase_reg != erase_reg) begin
							cnt_reg   <= steps(p.cfg.transition_count, 1'b0);
							state_reg <= ST_TRAN;
						end else begin
							cnt_reg <= erase_reg
								? steps(p.cfg.erase_pulse_count, 1'b1)
								: steps(p.cfg.program_pulse_count, 1'b0);
							state_reg <= ST_PULSE;
						end
					end else
						cnt_reg <= cnt_reg - 1'b1;
				end
			end
			ST_TRAN: begin
				if (tick) begin
					if (cnt_reg == '0) begin
						cnt_reg <= erase_reg
							? steps(p.cfg.erase_pulse_count, 1'b1)
							: steps(p.cfg.program_pulse_count, 1'b0);
						state_reg <= ST_PULSE;
					end else
						cnt_reg <= cnt_reg - 1'b1;
				end
			end
			// [RL1] [RL2] pulse width
			ST_PULSE: begin
				if (tick) begin
					if (cnt_reg == '0) begin
						last_erase_reg <= erase_reg;
						ran_reg        <= 1'b1;
						cnt_reg   <= steps(p.cfg.pump_end_count, 1'b0);
						state_reg <= ST_END;
					end else
						cnt_reg <= cnt_reg - 1'b1;
				end
			end
			// [RL5] pump end delay
			ST_END: begin
				if (tick) begin
					if (cnt_reg == '0) begin
						hold_reg  <= PUMP_HOLD_CYC - 2'h1;
						state_reg <= ST_PUMPHD;
					end else
						cnt_reg <= cnt_reg - 1'b1;
				end
			end
			// [RL12] pump enable extra cycle
			ST_PUMPHD: begin
				if (hold_reg == 2'h0)
					state_reg <= ST_IDLE;
				else
					hold_reg <= hold_reg - 2'h1;
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// [RL17] outputs follow phase order
	assign p.busy     = (state_reg != ST_IDLE);
	assign p.pump_on  = (state_reg != ST_IDLE) && (state_reg != ST_HOLD);
	assign p.pulse_on = (state_reg == ST_PULSE);
	assign p.is_erase = erase_reg;
	assign p.done     = (state_reg == ST_PUMPHD) && (hold_reg == 2'h0);
endmodule
